// file: design/pll_controller.sv
// Controller end: APB registers driving the three-wire link
module pll_controller import pll_pkg::*; #(
	parameter int REF_PERIOD_CYC = 1000
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst_b,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Tuner side
	input wire logic station_detect,
	output logic irq,
	// Serial link
	serial_if.ctl link
);
	typedef enum logic [1:0] {st_idle, st_low, st_high, st_tail} link_st_e;
	link_st_e st;
	logic [1:0] do_s;
	logic [1:0] sd_s;
	logic [7:0] ctrl;
	logic [IRQ_W-1:0] irq_en;
	logic [IRQ_W-1:0] irq_stat;
	logic [7:0] rdata;
	logic pend_wr;
	logic pend_rd;
	logic cur_rd;
	logic [31:0] settle;
	logic [1:0] reads_since;
	logic unlock_seen;
	logic [FRAME_BITS-1:0] tx_sh;
	logic [7:0] rx_sh;
	logic [3:0] bit_idx;
	logic [7:0] cnt;
	logic half_done;
	logic wr_en;
	logic start;
	logic done;
	logic ev_unlock;

	assign wr_en = psel & penable & pwrite & pready;
	assign half_done = cnt == 8'(CL_HALF_CYC - 1);
	assign start = st == st_idle && (pend_wr || (pend_rd && settle == 32'h0));

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			do_s <= 2'h3;
			sd_s <= 2'h0;
		end else begin
			do_s <= {do_s[0], link.do_line};
			sd_s <= {sd_s[0], station_detect};
		end
	end

	//------------------------------------------------------------
	// APB slave, answers one cycle after setup
	//------------------------------------------------------------
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0;
		end else begin
			pready <= psel & ~penable;
			pslverr <= psel & ~penable & (paddr > REG_IRQ_CLR || paddr[1:0] != 2'h0);
			prdata <= 32'h0;
			if (psel && !penable && !pwrite) begin
				unique case (paddr)
					REG_CTRL: prdata <= {24'h0, ctrl};
					REG_STATUS: prdata <= {27'h0, sd_s[1], unlock_seen,
						reads_since == 2'h2, settle != 32'h0, st != st_idle};
					REG_RDATA: prdata <= {24'h0, rdata};
					REG_IRQ_STAT: prdata <= {30'h0, irq_stat};
					REG_IRQ_EN: prdata <= {30'h0, irq_en};
					default: prdata <= 32'h0;
				endcase
			end
		end
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			ctrl <= CTRL_RST;
			irq_en <= '0;
		end else if (wr_en && paddr == REG_CTRL) begin
			ctrl <= pwdata[7:0];
		end else if (wr_en && paddr == REG_IRQ_EN) begin
			irq_en <= pwdata[IRQ_W-1:0];
		end
	end

	//------------------------------------------------------------
	// Command queue, settle wait and readout validity
	//------------------------------------------------------------
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			pend_wr <= 1'b0;
			pend_rd <= 1'b0;
			settle <= 32'h0;
			reads_since <= 2'h2;
		end else begin
			if (wr_en && paddr == REG_CMD && pwdata[CMD_WRITE])
				pend_wr <= 1'b1;
			else if (start && pend_wr)
				pend_wr <= 1'b0;
			if (wr_en && paddr == REG_CMD && pwdata[CMD_READ])
				pend_rd <= 1'b1;
			else if (start && !pend_wr)
				pend_rd <= 1'b0;
			if (wr_en && paddr == REG_CMD && pwdata[CMD_NEWDIV]) begin
				settle <= 32'(2 * REF_PERIOD_CYC);
				reads_since <= 2'h0;
			end else begin
				if (settle != 32'h0)
					settle <= settle - 32'h1;
				if (done && cur_rd && reads_since != 2'h2)
					reads_since <= reads_since + 2'h1;
			end
		end
	end

	assign ev_unlock = done && cur_rd && reads_since != 2'h0 && rx_sh[SW_UNLOCK];

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			rdata <= 8'h0;
			unlock_seen <= 1'b0;
		end else if (done && cur_rd) begin
			rdata <= rx_sh;
			if (reads_since != 2'h0)
				unlock_seen <= rx_sh[SW_UNLOCK];
		end
	end

	//------------------------------------------------------------
	// Interrupts, set wins over clear
	//------------------------------------------------------------
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			irq_stat <= '0;
			irq <= 1'b0;
		end else begin
			for (int i = 0; i < IRQ_W; i++) begin
				if ((i == IRQ_DONE && done) || (i == IRQ_UNLOCK && ev_unlock))
					irq_stat[i] <= 1'b1;
				else if (wr_en && paddr == REG_IRQ_CLR && pwdata[i])
					irq_stat[i] <= 1'b0;
			end
			irq <= |(irq_stat & irq_en);
		end
	end

	//------------------------------------------------------------
	// Link frame engine
	//------------------------------------------------------------
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			st <= st_idle;
			link.ce <= 1'b0;
			link.cl <= 1'b0;
			link.di <= 1'b0;
			tx_sh <= '0;
			rx_sh <= 8'h0;
			bit_idx <= 4'h0;
			cnt <= 8'h0;
			cur_rd <= 1'b0;
			done <= 1'b0;
		end else begin
			done <= 1'b0;
			cnt <= half_done ? 8'h0 : cnt + 8'h1;
			unique case (st)
				st_idle: begin
					cnt <= 8'h0;
					if (start) begin
						cur_rd <= ~pend_wr;
						tx_sh <= {~pend_wr, ctrl[7:CW_CTE+1],
							ctrl[CW_CTE] & sd_s[1], ctrl[CW_CTE-1:0]};
						link.di <= ~pend_wr;
						link.ce <= 1'b1;
						bit_idx <= 4'h0;
						st <= st_low;
					end
				end
				st_low: if (half_done) begin
					link.cl <= 1'b1;
					st <= st_high;
				end
				st_high: if (half_done) begin
					rx_sh <= {rx_sh[6:0], do_s[1]};
					link.cl <= 1'b0;
					tx_sh <= {tx_sh[FRAME_BITS-2:0], 1'b0};
					link.di <= tx_sh[FRAME_BITS-2];
					bit_idx <= bit_idx + 4'h1;
					st <= bit_idx == 4'(FRAME_BITS - 1) ? st_tail : st_low;
				end
				st_tail: if (half_done) begin
					link.ce <= 1'b0;
					done <= 1'b1;
					st <= st_idle;
				end
			endcase
		end
	end
endmodule

// file: design/pll_device.sv
// Synthesizer lock detection, dead-zone pump control and data-out mux
module pll_device import pll_pkg::*; #(
	parameter int LOCK_WIN = 2,
	parameter int ONON_MIN = 2,
	parameter int DZ_C_CYC = 2,
	parameter int DZ_D_CYC = 4
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst_b,
	// Serial link
	serial_if.dev link,
	// Loop and counter side
	input wire logic ref_tick,
	input wire logic div_tick,
	input wire logic if_done,
	input wire logic aux_pin,
	// Pump and counter control
	output logic cp_up,
	output logic cp_dn,
	output logic unlock_now,
	output logic [1:0] dead_zone_mode,
	output logic count_enable,
	output logic if_start,
	output logic if_reset
);
	logic [1:0] ce_s;
	logic [1:0] cl_s;
	logic [1:0] di_s;
	logic [1:0] aux_s;
	logic ce_d;
	logic cl_d;
	logic ce_fall;
	logic cl_rise;
	logic cl_fall;
	logic [3:0] bit_cnt;
	logic rd_frame;
	logic [DATA_BITS-1:0] rx_sh;
	logic [DATA_BITS-1:0] tx_sh;
	logic [DATA_BITS-1:0] ctrl;
	logic unlock_flag;
	logic [1:0] div_cnt;
	logic [1:0] next_div_cnt;
	logic [7:0] phase_cnt;
	logic [7:0] since_div;
	logic near_early;
	logic near_hit;
	logic up_raw;
	logic dn_raw;
	logic [7:0] wcnt;
	logic [7:0] pulse_cnt;
	logic [7:0] dz_cyc;
	logic tx_active;
	logic tx_loaded;
	logic do_bit;

	//------------------------------------------------------------
	// Pin synchronisers and edge finding
	//------------------------------------------------------------
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			ce_s <= 2'h0;
			cl_s <= 2'h0;
			di_s <= 2'h0;
			aux_s <= 2'h0;
			ce_d <= 1'b0;
			cl_d <= 1'b0;
		end else begin
			ce_s <= {ce_s[0], link.ce};
			cl_s <= {cl_s[0], link.cl};
			di_s <= {di_s[0], link.di};
			aux_s <= {aux_s[0], aux_pin};
			ce_d <= ce_s[1];
			cl_d <= cl_s[1];
		end
	end

	assign ce_fall = ce_d & ~ce_s[1];
	assign cl_rise = ~cl_d & cl_s[1];
	assign cl_fall = cl_d & ~cl_s[1];

	//------------------------------------------------------------
	// Serial receive and control latch
	//------------------------------------------------------------
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			bit_cnt <= 4'h0;
			rd_frame <= 1'b0;
			rx_sh <= '0;
		end else if (!ce_s[1]) begin
			bit_cnt <= 4'h0;
		end else if (cl_rise) begin
			if (bit_cnt != 4'(FRAME_BITS))
				bit_cnt <= bit_cnt + 4'h1;
			if (bit_cnt == 4'h0)
				rd_frame <= di_s[1];
			else
				rx_sh <= {rx_sh[DATA_BITS-2:0], di_s[1]};
		end
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b)
			ctrl <= '0;
		else if (ce_fall && !rd_frame && bit_cnt == 4'(FRAME_BITS))
			ctrl <= rx_sh;
	end

	//------------------------------------------------------------
	// Status readout shifter
	//------------------------------------------------------------
	// Readout owns the pin only once the status byte is loaded, so the
	// line never moves while the serial clock is high in do_serial mode
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			tx_sh <= '0;
			tx_loaded <= 1'b0;
		end else if (!ce_s[1]) begin
			tx_loaded <= 1'b0;
		end else if (rd_frame && cl_fall) begin
			if (bit_cnt == 4'h1) begin
				tx_loaded <= 1'b1;
				tx_sh <= '0;
				tx_sh[SW_UNLOCK] <= unlock_flag;
				tx_sh[SW_LOCKED_NOW] <= ~unlock_now;
				tx_sh[SW_IF_DONE] <= if_done;
			end else begin
				tx_sh <= {tx_sh[DATA_BITS-2:0], 1'b0};
			end
		end
	end

	assign tx_active = ce_s[1] & tx_loaded;

	//------------------------------------------------------------
	// Lock judgement per reference period
	//------------------------------------------------------------
	assign next_div_cnt = (div_tick && div_cnt != 2'h3) ? div_cnt + 2'h1 : div_cnt;
	assign near_hit = near_early | (since_div <= 8'(LOCK_WIN)) | div_tick;

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			div_cnt <= 2'h0;
			phase_cnt <= 8'h0;
			since_div <= 8'hff;
			near_early <= 1'b0;
			unlock_now <= 1'b1;
		end else if (ref_tick) begin
			unlock_now <= !(next_div_cnt == 2'h1 && near_hit);
			div_cnt <= 2'h0;
			phase_cnt <= 8'h0;
			near_early <= 1'b0;
			since_div <= 8'hff;
		end else begin
			div_cnt <= next_div_cnt;
			if (phase_cnt != 8'hff)
				phase_cnt <= phase_cnt + 8'h1;
			if (div_tick) begin
				since_div <= 8'h0;
				near_early <= near_early | (phase_cnt <= 8'(LOCK_WIN));
			end else if (since_div != 8'hff) begin
				since_div <= since_div + 8'h1;
			end
		end
	end

	// Sticky flag, a new detection wins over the clear
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b)
			unlock_flag <= 1'b0;
		else if (ref_tick && !(next_div_cnt == 2'h1 && near_hit))
			unlock_flag <= 1'b1;
		else if (ce_fall)
			unlock_flag <= 1'b0;
	end

	//------------------------------------------------------------
	// Phase comparator and charge pump
	//------------------------------------------------------------
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			up_raw <= 1'b0;
			dn_raw <= 1'b0;
			wcnt <= 8'h0;
			pulse_cnt <= 8'hff;
		end else begin
			if (ref_tick && !div_tick) begin
				up_raw <= ~dn_raw;
				dn_raw <= 1'b0;
			end else if (div_tick && !ref_tick) begin
				dn_raw <= ~up_raw;
				up_raw <= 1'b0;
			end
			if (ref_tick || div_tick)
				wcnt <= 8'h0;
			else if (wcnt != 8'hff)
				wcnt <= wcnt + 8'h1;
			if (ref_tick)
				pulse_cnt <= 8'h0;
			else if (pulse_cnt != 8'hff)
				pulse_cnt <= pulse_cnt + 8'h1;
		end
	end

	always_comb begin
		dz_cyc = 8'(DZ_C_CYC);
		if (dead_zone_e'(dead_zone_mode) == dead_zone_mode_d)
			dz_cyc = 8'(DZ_D_CYC);
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			cp_up <= 1'b0;
			cp_dn <= 1'b0;
			dead_zone_mode <= 2'h0;
		end else begin
			dead_zone_mode <= {ctrl[CW_DZ_HI], ctrl[CW_DZ_LO]};
			unique case (dead_zone_e'(dead_zone_mode))
				no_dead_zone_mode_a, no_dead_zone_mode_b: begin
					cp_up <= up_raw | (pulse_cnt < 8'(ONON_MIN));
					cp_dn <= dn_raw | (pulse_cnt < 8'(ONON_MIN));
				end
				dead_zone_mode_c, dead_zone_mode_d: begin
					cp_up <= up_raw & (wcnt >= dz_cyc);
					cp_dn <= dn_raw & (wcnt >= dz_cyc);
				end
			endcase
		end
	end

	//------------------------------------------------------------
	// IF counter control
	//------------------------------------------------------------
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			count_enable <= 1'b0;
			if_start <= 1'b0;
			if_reset <= 1'b1;
		end else begin
			count_enable <= ctrl[CW_CTE];
			if_start <= ctrl[CW_CTE] & ~count_enable;
			if_reset <= ~ctrl[CW_CTE];
		end
	end

	//------------------------------------------------------------
	// Data-out pin select, open drain
	//------------------------------------------------------------
	always_comb begin
		unique case (do_sel_e'({ctrl[CW_DOSEL_HI], ctrl[CW_DOSEL_LO]}))
			do_serial: do_bit = tx_active ? tx_sh[DATA_BITS-1] : 1'b1;
			do_lock: do_bit = ~unlock_now;
			do_if_done: do_bit = if_done;
			do_pass: do_bit = aux_s[1];
		endcase
		if (tx_active)
			do_bit = tx_sh[DATA_BITS-1];
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			link.do_o <= 1'b0;
			link.do_oe <= 1'b0;
		end else begin
			link.do_o <= 1'b0;
			link.do_oe <= ~do_bit;
		end
	end
endmodule

// file: design/pll_pkg.sv
// Shared constants and types for the synthesizer lock-status link
//------------------------------------------------------------
//------------------------------------------------------------
package pll_pkg;
	// Serial frame: one direction bit then one data byte, MSB first
	localparam int DATA_BITS = 8;
	localparam int FRAME_BITS = 9;
	// Control byte fields
	localparam int CW_DZ_LO = 0;
	localparam int CW_DZ_HI = 1;
	localparam int CW_DOSEL_LO = 2;
	localparam int CW_DOSEL_HI = 3;
	localparam int CW_CTE = 4;
	// Status byte fields
	localparam int SW_UNLOCK = 7;
	localparam int SW_LOCKED_NOW = 6;
	localparam int SW_IF_DONE = 5;
	// Controller register map
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_CMD = 8'h04;
	localparam logic [7:0] REG_STATUS = 8'h08;
	localparam logic [7:0] REG_RDATA = 8'h0c;
	localparam logic [7:0] REG_IRQ_STAT = 8'h10;
	localparam logic [7:0] REG_IRQ_EN = 8'h14;
	localparam logic [7:0] REG_IRQ_CLR = 8'h18;
	localparam logic [7:0] CTRL_RST = 8'h02;
	localparam int CMD_WRITE = 0;
	localparam int CMD_READ = 1;
	localparam int CMD_NEWDIV = 2;
	localparam int ST_BUSY = 0;
	localparam int ST_SETTLING = 1;
	localparam int ST_UNLOCK_VALID = 2;
	localparam int ST_UNLOCK_SEEN = 3;
	localparam int ST_STATION = 4;
	localparam int IRQ_W = 2;
	localparam int IRQ_DONE = 0;
	localparam int IRQ_UNLOCK = 1;
	// Link timing
	localparam int CLK_NS = 20;
	localparam int T_CL_NS = 750;
	localparam int CL_HALF_CYC = (T_CL_NS + CLK_NS - 1) / CLK_NS;
	typedef enum logic [1:0] {
		no_dead_zone_mode_a,
		no_dead_zone_mode_b,
		dead_zone_mode_c,
		dead_zone_mode_d
	} dead_zone_e;
	typedef enum logic [1:0] {do_serial, do_lock, do_if_done, do_pass} do_sel_e;
endpackage

// file: design/serial_if.sv
// Three-wire serial link with open-drain data-out line
interface serial_if;
	logic ce;
	logic cl;
	logic di;
	logic do_o;
	logic do_oe;
	wire logic do_line;
	// External pull-up holds the line high when released
	assign do_line = do_oe ? do_o : 1'b1;
	modport dev (input ce, input cl, input di, output do_o, output do_oe);
	modport ctl (output ce, output cl, output di, input do_line);
endinterface

// file: tb/pll_chk.sv
// Checker for the three-wire link between controller and device
module pll_chk import pll_pkg::*; (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst_b,
	// Link wires
	input wire logic ce,
	input wire logic cl,
	input wire logic di,
	input wire logic do_o,
	input wire logic do_oe,
	input wire logic do_line
);
	int hi_n;
	int lo_n;
	int bit_n;
	logic pcl;
	logic rd;
	//------------------------------
	// Half-period and bit counters
	//------------------------------
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			hi_n <= 0;
			lo_n <= 0;
			bit_n <= 0;
			pcl <= 1'b0;
			rd <= 1'b0;
		end else begin
			hi_n <= cl ? hi_n + 1 : 0;
			lo_n <= (ce && !cl) ? lo_n + 1 : 0;
			bit_n <= ce ? bit_n + int'(cl && !pcl) : 0;
			pcl <= cl;
			rd <= !ce ? 1'b0 : (cl && !pcl && bit_n == 0) ? di : rd;
		end
	end
	//------------------------------
	// Properties
	//------------------------------
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_b);
	sequence s_setup;
		(ce && !cl) [*8];
	endsequence
	sequence s_end;
		$fell(ce) ##1 !ce;
	endsequence
	property p_setup;
		$rose(ce) |-> s_setup;
	endproperty
	property p_lo;
		$rose(cl) |-> ce && lo_n >= CL_HALF_CYC;
	endproperty
	property p_hi;
		$fell(cl) |-> hi_n >= CL_HALF_CYC;
	endproperty
	property p_hold;
		cl && $past(cl) |-> $stable(di);
	endproperty
	property p_bits;
		$fell(ce) |-> !cl && bit_n == FRAME_BITS;
	endproperty
	property p_gap;
		$fell(ce) |-> s_end;
	endproperty
	property p_od;
		do_oe |-> !do_o;
	endproperty
	property p_do_edge;
		ce && rd && $changed(do_oe) |-> !cl;
	endproperty
	a_setup: assert property (p_setup)
		else $error("serial clock moved too soon after select");
	a_lo: assert property (p_lo)
		else $error("serial clock low half too short");
	a_hi: assert property (p_hi)
		else $error("serial clock high half too short");
	a_hold: assert property (p_hold)
		else $error("data moved while clock high");
	a_bits: assert property (p_bits)
		else $error("frame bit count wrong");
	a_gap: assert property (p_gap)
		else $error("no idle cycle between frames");
	a_od: assert property (p_od)
		else $error("data-out driven high");
	a_do_edge: assert property (p_do_edge)
		else $error("readout changed while clock high");
endmodule

// file: tb/testbench.sv
// Bench for the controller and device joined across the link
module testbench import pll_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;
	logic core_clk = 0, rst_b = 0, psel = 0, penable = 0, pwrite = 0;
	logic [7:0] paddr = 0;
	logic [31:0] pwdata = 0, prdata, r;
	logic pready, pslverr, perr, irq, station_detect = 0, v;
	logic ref_tick = 0, div_tick = 0, if_done = 0, aux_pin = 0, locked = 1;
	logic cp_up, cp_dn, unlock_now, count_enable, if_start, if_reset;
	logic [1:0] dead_zone_mode;
	logic [8:0] exp_q[$];
	logic [8:0] sh = 0, e;
	logic pcl = 0, pce = 0;
	int n_errors = 0, comparisons = 0, rc = 0, ncp = 0, nst = 0, ctrl_m = 2, en_m = 0;
	serial_if lk();
	pll_device u_pll_device (.core_clk, .rst_b, .link(lk), .ref_tick, .div_tick,
		.if_done, .aux_pin, .cp_up, .cp_dn, .unlock_now, .dead_zone_mode,
		.count_enable, .if_start, .if_reset);
	pll_controller #(.REF_PERIOD_CYC(20)) u_pll_controller (.core_clk, .rst_b,
		.psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
		.station_detect, .irq, .link(lk));
	pll_chk u_pll_chk (.core_clk, .rst_b, .ce(lk.ce), .cl(lk.cl), .di(lk.di),
		.do_o(lk.do_o), .do_oe(lk.do_oe), .do_line(lk.do_line));
	initial forever #10 core_clk = ~core_clk;
	//------------------------------
	// Loop stimulus and link sniffer
	//------------------------------
	always @(posedge core_clk) begin
		rc <= rc == 19 ? 0 : rc + 1;
		ref_tick <= rc == 19;
		div_tick <= rc == 19 && locked;
		if (cp_up === 1'b1 || cp_dn === 1'b1) ncp++;
		if (if_start === 1'b1) nst++;
		if (lk.ce && lk.cl && !pcl) sh = {sh[7:0], lk.di};
		if (pce && !lk.ce && exp_q.size() > 0) begin
			e = exp_q.pop_front();
			chk(e[8] ? {sh[8], 8'h00} : sh, e[8] ? 9'h100 : e, "frame bits");
		end
		pcl = lk.cl;
		pce = lk.ce;
	end
	//------------------------------
	// Tasks
	//------------------------------
	task automatic chk(input logic [31:0] g, input logic [31:0] x, input string m);
		comparisons++;
		if (g !== x) begin
			n_errors++;
			$display("CHECK FAILED %0t %s got %h exp %h", $time, m, g, x);
		end
	endtask
	task automatic summarize;
		$display("comparisons %0d mismatches %0d", comparisons, n_errors);
		if (n_errors == 0 && comparisons > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1;
		do begin
			@(posedge core_clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1) begin
			chk(0, 1, "bus hang");
			summarize();
		end
		r = prdata;
		perr = pslverr;
		psel <= 0;
		penable <= 0;
		@(posedge core_clk);
	endtask
	task automatic send(input logic rdf);
		logic [7:0] b;
		int n;
		b = ctrl_m[7:0];
		b[4] = b[4] & station_detect;
		n = 0;
		exp_q.push_back({rdf, b});
		apb(1, REG_CMD, rdf ? 2 : 1);
		do begin
			apb(0, REG_IRQ_STAT, 0);
			n++;
		end while (r[IRQ_DONE] !== 1'b1 && n < 400);
		if (r[IRQ_DONE] !== 1'b1) begin
			chk(0, 1, "frame hang");
			summarize();
		end
		chk(irq, en_m, "irq raised");
		apb(1, REG_IRQ_CLR, 1);
		apb(0, REG_STATUS, 0);
		chk(r[ST_BUSY], 0, "busy");
		chk(irq, 0, "irq cleared");
	endtask
	task automatic setc(input int c);
		ctrl_m = c;
		apb(1, REG_CTRL, c);
		send(0);
	endtask
	//------------------------------
	// Main sequence
	//------------------------------
	initial begin
		r = $urandom(65737);
		repeat (12) @(posedge core_clk);
		rst_b <= 1;
		apb(0, REG_CTRL, 0);
		chk(r, 32'h2, "ctrl reset");
		apb(1, 8'h1c, 5);
		chk(perr, 1, "unmapped");
		en_m = 1;
		apb(1, REG_IRQ_EN, 1);
		$display("test registers done");
		for (int m = 0; m < 4; m++) begin
			setc(m);
			chk(dead_zone_mode, m, "dead zone");
			ncp = 0;
			repeat (100) @(posedge core_clk);
			chk(ncp > 0, m < 2, "pump pulses");
		end
		$display("test dead zone done");
		en_m = 0;
		apb(1, REG_IRQ_EN, 0);
		for (int s = 1; s < 4; s++) begin
			setc(s << 2);
			for (int k = 0; k < 4; k++) begin
				v = k == 0 ? 1'($urandom % 2) : !v;
				if (s == 1) locked <= v;
				else if (s == 2) if_done <= v;
				else aux_pin <= v;
				repeat (70) @(posedge core_clk);
				chk(lk.do_line, v, "data-out");
				if (s == 1) chk(unlock_now, !v, "unlock now");
			end
		end
		locked <= 1;
		$display("test data-out done");
		setc(0);
		locked <= 0;
		repeat (60) @(posedge core_clk);
		apb(1, REG_CMD, 4);
		locked <= 1;
		apb(0, REG_STATUS, 0);
		chk(r[ST_SETTLING], 1, "settling");
		send(1);
		apb(0, REG_RDATA, 0);
		chk(r[SW_UNLOCK], 1, "stale flag");
		apb(0, REG_STATUS, 0);
		chk(r[ST_UNLOCK_VALID], 0, "stale valid");
		apb(0, REG_IRQ_STAT, 0);
		chk(r[IRQ_UNLOCK], 0, "stale no event");
		send(1);
		apb(0, REG_RDATA, 0);
		chk(r[SW_UNLOCK], 0, "flag cleared");
		chk(r[SW_LOCKED_NOW], 1, "locked now");
		apb(0, REG_STATUS, 0);
		chk(r[ST_UNLOCK_VALID], 1, "second valid");
		chk(lk.do_line, 1, "line released");
		locked <= 0;
		repeat (50) @(posedge core_clk);
		locked <= 1;
		repeat (60) @(posedge core_clk);
		send(1);
		apb(0, REG_RDATA, 0);
		chk(r[SW_UNLOCK], 1, "flag sticks");
		apb(0, REG_STATUS, 0);
		chk(r[ST_UNLOCK_SEEN], 1, "unlock seen");
		apb(0, REG_IRQ_STAT, 0);
		chk(r[IRQ_UNLOCK], 1, "unlock event");
		$display("test unlock flag done");
		setc(16);
		chk(count_enable, 0, "no station");
		station_detect <= 1;
		repeat (5) @(posedge core_clk);
		nst = 0;
		setc(16);
		chk(count_enable, 1, "count on");
		chk(if_reset, 0, "reset off");
		chk(nst, 1, "one start");
		setc(0);
		chk(if_reset, 1, "reset on");
		$display("test counter done");
		chk(exp_q.size(), 0, "frames left");
		summarize();
	end
endmodule
